// ===== inc/irc_defines.svh
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH

// Bit time in sixteen-times clock ticks
`define IRC_BIT_TICKS      5'h10
// Encoder tick phase at which the optical pulse rises
`define IRC_ENC_WAIT       4'h7
// Optical pulse length in ticks
`define IRC_ENC_HIGH       4'h3
// Last tick phase of a bit
`define IRC_PHASE_LAST     4'hF
// Shortest stretched zero that a UART samples correctly
`define IRC_RX_MIN_TICKS   5'h0C
// Reset levels of the outputs and sampled lines
`define IRC_TX_IDLE        1'b0
`define IRC_RX_IDLE        1'b1
`define IRC_SYNC_RESET     4'h0

`endif

// ===== inc/irc_pkg.sv
package irc_pkg;

  typedef enum logic {
    IRC_ENC_IDLE   = 1'b0,
    IRC_ENC_ACTIVE = 1'b1
  } irc_enc_state_e;

  typedef enum logic {
    IRC_DEC_IDLE    = 1'b0,
    IRC_DEC_STRETCH = 1'b1
  } irc_dec_state_e;

  // High to low change between two tick samples
  function automatic logic irc_fell(input logic prev, input logic cur);
    irc_fell = prev & ~cur;
  endfunction

endpackage

// ===== hdl/irc_sync.sv
`timescale 1ns/10ps
`include "irc_defines.svh"

module irc_sync (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Asynchronous lines
  input  wire logic [3:0] async_in,
  // Filtered lines
  output logic      [3:0] sync_out
);

  logic [3:0] stage1;
  logic [3:0] stage2;
  logic [3:0] stage3;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1 <= `IRC_SYNC_RESET;
      stage2 <= `IRC_SYNC_RESET;
      stage3 <= `IRC_SYNC_RESET;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once the two later stages agree
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_out <= `IRC_SYNC_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// ===== hdl/irc_codec.sv
`timescale 1ns/10ps
`include "irc_defines.svh"

// What this block does
// - Both machines step on sixteen-times clock rises; decoder reset low acts on any ref clock
// - One optical pulse per zero bit
// - Wait seven ticks, pulse high three ticks
// - Optical falling edge gives sixteen-tick zero
// - Stretched zero lasts at least three-quarter bit
// - Low decoder reset holds decoder in reset
// - Decoder reset low blocks all reception
module irc_codec
  import irc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // UART side
  input  wire logic sixteen_times_bit_clock_in,
  input  wire logic uart_serial_output_in,
  input  wire logic decoder_reset_n_in,
  output logic      serial_rx_out,
  // Transceiver side
  input  wire logic optical_rx_pulse_in,
  output logic      optical_tx_pulse_out
);

  logic [3:0]     line_sync;
  logic           bit_clk;
  logic           tx_line;
  logic           dec_run_n;
  logic           ir_line;
  logic           bit_clk_prev;
  logic           tick;
  logic           tx_prev;
  logic           ir_prev;
  logic           enc_start;
  logic           dec_start;
  logic           dec_hold;
  logic [3:0]     enc_phase;
  logic [3:0]     next_enc_phase;
  logic [3:0]     dec_cnt;
  irc_enc_state_e enc_state;
  irc_dec_state_e dec_state;

  irc_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({optical_rx_pulse_in, decoder_reset_n_in, uart_serial_output_in, sixteen_times_bit_clock_in}),
    .sync_out   (line_sync)
  );

  assign bit_clk   = line_sync[0];
  assign tx_line   = line_sync[1];
  assign dec_run_n = line_sync[2];
  assign ir_line   = line_sync[3];
  assign dec_hold  = ~dec_run_n;

  // Tick enable on each rise of the outside clock
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_clk_prev <= 1'b0;
    end else begin
      bit_clk_prev <= bit_clk;
    end
  end

  assign tick = bit_clk & ~bit_clk_prev;

  // Encoder
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_prev <= 1'b1;
    end else if (tick) begin
      tx_prev <= tx_line;
    end
  end

  assign enc_start = tick && irc_fell(tx_prev, tx_line);

  // Phase runs over one bit; a line still low at the wrap is another zero
  always_comb begin
    next_enc_phase = enc_phase + 4'h1;
    if (enc_start) begin
      next_enc_phase = 4'h0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enc_state <= IRC_ENC_IDLE;
      enc_phase <= 4'h0;
    end else if (enc_start) begin
      enc_state <= IRC_ENC_ACTIVE;
      enc_phase <= next_enc_phase;
    end else if (tick && enc_state == IRC_ENC_ACTIVE) begin
      enc_phase <= next_enc_phase;
      if (enc_phase == `IRC_PHASE_LAST && tx_line) begin
        enc_state <= IRC_ENC_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      optical_tx_pulse_out <= `IRC_TX_IDLE;
    end else if (enc_start) begin
      optical_tx_pulse_out <= `IRC_TX_IDLE;
    end else if (tick) begin
      optical_tx_pulse_out <= (enc_state == IRC_ENC_ACTIVE) && (next_enc_phase >= `IRC_ENC_WAIT)
                              && (next_enc_phase < `IRC_ENC_WAIT + `IRC_ENC_HIGH);
    end
  end

  // Decoder
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ir_prev <= 1'b0;
    end else if (dec_hold) begin
      ir_prev <= 1'b0;
    end else if (tick) begin
      ir_prev <= ir_line;
    end
  end

  assign dec_start = tick && !dec_hold && irc_fell(ir_prev, ir_line);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dec_state     <= IRC_DEC_IDLE;
      dec_cnt       <= 4'h0;
      serial_rx_out <= `IRC_RX_IDLE;
    end else if (dec_hold) begin
      dec_state     <= IRC_DEC_IDLE;
      dec_cnt       <= 4'h0;
      serial_rx_out <= `IRC_RX_IDLE;
    end else if (dec_start) begin
      dec_state     <= IRC_DEC_STRETCH;
      dec_cnt       <= 4'h0;
      serial_rx_out <= 1'b0;
    end else if (tick) begin
      case (dec_state)
        IRC_DEC_STRETCH: begin
          dec_cnt <= dec_cnt + 4'h1;
          if (dec_cnt == `IRC_PHASE_LAST) begin
            dec_state     <= IRC_DEC_IDLE;
            serial_rx_out <= `IRC_RX_IDLE;
          end
        end
        default: begin
          dec_cnt <= 4'h0;
        end
      endcase
    end
  end

  // Helper counts for the checks below
  logic [4:0] tx_hi_ticks;
  logic [4:0] rx_lo_ticks;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_hi_ticks <= 5'h00;
      rx_lo_ticks <= 5'h00;
    end else begin
      if (!optical_tx_pulse_out) begin
        tx_hi_ticks <= 5'h00;
      end else if (tick) begin
        tx_hi_ticks <= tx_hi_ticks + 5'h01;
      end
      if (dec_start || dec_hold) begin
        rx_lo_ticks <= 5'h00;
      end else if (tick && !serial_rx_out) begin
        rx_lo_ticks <= rx_lo_ticks + 5'h01;
      end
    end
  end

  tick_single_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tick |=> !tick) else $error("tick enable lasted more than one cycle");

  enc_quiet_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    enc_state == IRC_ENC_IDLE |-> !optical_tx_pulse_out) else $error("optical pulse while encoder idle");

  pulse_delay_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(optical_tx_pulse_out) |-> enc_phase == `IRC_ENC_WAIT) else $error("optical pulse not seven ticks late");

  pulse_width_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $fell(optical_tx_pulse_out) && !$past(enc_start) |-> tx_hi_ticks == 5'h03)
    else $error("optical pulse not three ticks long");

  rx_stretch_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(serial_rx_out) && !$past(dec_hold) |-> rx_lo_ticks == `IRC_BIT_TICKS)
    else $error("stretched zero not one bit long");

  rx_min_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(serial_rx_out) && !$past(dec_hold) |-> rx_lo_ticks >= `IRC_RX_MIN_TICKS)
    else $error("stretched zero shorter than three quarter bit");

  dec_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    dec_hold |=> serial_rx_out && dec_state == IRC_DEC_IDLE) else $error("decoder not held in reset");

  rx_block_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    dec_hold ##1 dec_hold |-> serial_rx_out && !dec_start) else $error("reception while decoder reset low");

  restart_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    dec_start |=> dec_cnt == 4'h0 && !serial_rx_out) else $error("new optical edge did not restart stretch");

endmodule

// ===== testbench/irc_far_model.sv
`timescale 1ns/10ps

module irc_far_model (
  // Clock
  input  wire logic ref_clk_in,
  // Toward the codec
  output logic      bit_clk_out,
  output logic      tx_line_out,
  output logic      ir_line_out
);
  logic [4:0] phase = 5'h00;

  // 32 ref cycles per tick keeps the rate under 2 MHz
  always_ff @(posedge ref_clk_in) begin
    phase <= phase + 5'h01;
  end
  assign bit_clk_out = ~phase[4];

  initial begin
    tx_line_out = 1'b1;
    ir_line_out = 1'b1;
  end

  // Lines change mid-tick so no tick sees them move
  task automatic mid_tick();
    do @(posedge ref_clk_in); while (phase != 5'h0F);
  endtask

  task automatic send_bit(input logic b);
    mid_tick();
    tx_line_out <= b;
  endtask

  // Active-low transceiver pulse, three ticks long
  task automatic ir_pulse();
    mid_tick();
    ir_line_out <= 1'b0;
    repeat (3) mid_tick();
    ir_line_out <= 1'b1;
  endtask
endmodule

// ===== testbench/irc_codec_bench.sv
`timescale 1ns/10ps

module irc_codec_bench;
  logic ref_clk_in         = 1'b0;
  logic rst_in             = 1'b1;
  logic decoder_reset_n_in = 1'b1;
  logic bit_clk;
  logic tx_line;
  logic ir_line;
  logic serial_rx_out;
  logic optical_tx_pulse_out;
  int   n_fail   = 0;
  int   n_checks = 0;
  int   tx_hi    = 0;
  int   rx_lo    = 0;
  int   n_pulse  = 0;
  int   since    = 0;
  int   lat      = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  irc_far_model far (
    .ref_clk_in (ref_clk_in),
    .bit_clk_out(bit_clk),
    .tx_line_out(tx_line),
    .ir_line_out(ir_line)
  );

  irc_codec uut (
    .ref_clk_in                (ref_clk_in),
    .rst_in                    (rst_in),
    .sixteen_times_bit_clock_in(bit_clk),
    .uart_serial_output_in     (tx_line),
    .decoder_reset_n_in        (decoder_reset_n_in),
    .serial_rx_out             (serial_rx_out),
    .optical_rx_pulse_in       (ir_line),
    .optical_tx_pulse_out      (optical_tx_pulse_out)
  );

  // Outputs move a few ref cycles after a tick, so rises see settled values
  always @(posedge bit_clk) begin
    since++;
    if (optical_tx_pulse_out) tx_hi++;
    if (!serial_rx_out) rx_lo++;
  end
  always @(negedge tx_line) since = 0;
  always @(posedge optical_tx_pulse_out) begin
    n_pulse++;
    lat = since;
  end

  task automatic chk_num(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_fail++;
      $display("FAIL %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t level %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge bit_clk);
  endtask

  task automatic clear();
    tx_hi = 0;
    rx_lo = 0;
    n_pulse = 0;
  endtask

  // Bits 0,0,1,0,1 sent LSB first, sixteen ticks each
  task automatic t_encode();
    logic [4:0] bits;
    bits = 5'h14;
    clear();
    for (int i = 0; i < 5; i++) begin
      far.send_bit(bits[i]);
      repeat (15) far.mid_tick();
    end
    far.send_bit(1'b1);
    ticks(20);
    chk_num(n_pulse, 3);
    chk_num(tx_hi, 9);
    chk_num(lat, 7 + 1);
  endtask

  task automatic t_decode();
    clear();
    far.ir_pulse();
    ticks(24);
    chk_num(rx_lo, 16);
    chk_bit(serial_rx_out, 1'b1);
  endtask

  // Second pulse eight ticks after the first
  task automatic t_restart();
    clear();
    far.ir_pulse();
    repeat (4) far.mid_tick();
    far.ir_pulse();
    ticks(30);
    chk_num(rx_lo, 8 + 16);
  endtask

  // Decoder reset lands mid-stretch, then blocks a pulse
  task automatic t_block();
    far.ir_pulse();
    @(posedge ref_clk_in);
    decoder_reset_n_in <= 1'b0;
    ticks(1);
    chk_bit(serial_rx_out, 1'b1);
    clear();
    far.ir_pulse();
    ticks(20);
    chk_num(rx_lo, 0);
    @(posedge ref_clk_in);
    decoder_reset_n_in <= 1'b1;
    ticks(2);
    t_decode();
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_in);
    chk_bit(serial_rx_out, 1'b1);
    chk_bit(optical_tx_pulse_out, 1'b0);
    rst_in <= 1'b0;
    ticks(2);
    t_encode();
    t_decode();
    t_restart();
    t_block();
    end_sim();
  end

  // About 7200 cycles expected; cut off well beyond
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    n_fail++;
    end_sim();
  end
endmodule
